// ---- inc/cfs_regs.vh ----
`ifndef CFS_REGS_VH
`define CFS_REGS_VH

// register numbers (16-bit word index); byte address is four times the index
`define CFS_IDX_FAULT_LO 16'hA320
`define CFS_IDX_FAULT_HI 16'hA321
`define CFS_IDX_CURVE_LO 16'hA322
`define CFS_IDX_CURVE_HI 16'hA323
`define CFS_IDX_THERM_LO 16'hA324
`define CFS_IDX_THERM_HI 16'hA325
`define CFS_IDX_FAN 16'hA326
`define CFS_IDX_RESULT 16'hA327
`define CFS_IDX_PARTNUM 16'hA328

// bit fields of the byte address and of the flag words
`define CFS_HALF_LO 15:0
`define CFS_HALF_HI 31:16
`define CFS_ADDR_INDEX 17:2
`define CFS_ADDR_BYTE 1:0
`define CFS_ADDR_TOP 31:18
`define CFS_ADDR_BYTE_ZERO 2'h0
`define CFS_ADDR_TOP_ZERO 14'h0000
`define CFS_F_LOWER_OC 2:0
`define CFS_F_UPPER_OC 5:3
`define CFS_F_PHASE_OC 8:6
`define CFS_F_CUR_IMBAL 11:9
`define CFS_F_LINK_HW_OV 13:12
`define CFS_F_LINK_OV 14
`define CFS_F_LINK_IMBAL 15
`define CFS_F_PRECHARGE 16
`define CFS_F_BIAS_UV 17
`define CFS_F_INTERLOCK 18
`define CFS_F_DCDC_COMM 19
`define CFS_F_LOG_ERR 20
`define CFS_F_FACT_CFG 21
`define CFS_F_CFG_MEM 22
`define CFS_F_CAL_ERR 23
`define CFS_C_LOW_V 1
`define CFS_C_HIGH_V 2
`define CFS_C_LOW_F 3
`define CFS_T_DC_SINK_HOT 2:0
`define CFS_T_DC_SINK_IMBAL 3
`define CFS_T_DC_SWITCH_HOT 6:4
`define CFS_T_AC_SINK_HOT 9:7
`define CFS_T_AC_SINK_IMBAL 10
`define CFS_T_AMBIENT_HIGH 24
`define CFS_T_AMBIENT_LOW 25
`define CFS_N_FAN_STOPPED 2
`define CFS_N_FAN_SLOW 3

// legal bit masks of the status words
`define CFS_FAULT_MASK 32'h00FF_FFFF
`define CFS_CURVE_MASK 32'h0000_000E
`define CFS_THERM_MASK 32'h0300_07FF
`define CFS_FAN_MASK 16'h000C

// access result codes
`define CFS_RES_OK 16'h0000
`define CFS_RES_BAD_REG 16'h0001
`define CFS_RES_WR_RO 16'h0002
`define CFS_RES_RD_WO 16'h0003
`define CFS_RES_RANGE 16'h0004
`define CFS_RES_MEM_HW 16'h0005
`define CFS_RES_MEM_CRC 16'h0006
`define CFS_RES_PASSWORD 16'h0007
`define CFS_RES_RUNNING 16'h0008

`define CFS_RESULT_RESET 16'h0000
`define CFS_ZERO32 32'h0000_0000
`define CFS_ZERO16 16'h0000
`define CFS_PARTNUM_DEFAULT 16'h1234

`endif

// ---- hdl/cfs_flag_capture.v ----
`timescale 1ns/1ps
`include "cfs_regs.vh"

module cfs_flag_capture
(
    input wire i_clk,
    input wire i_rst,
    input wire [31:0] i_fault,
    input wire [31:0] i_curve,
    input wire [31:0] i_therm,
    input wire [15:0] i_fan,
    output reg [31:0] o_fault,
    output reg [31:0] o_curve,
    output reg [31:0] o_therm,
    output reg [15:0] o_fan
);

    // reserved bits are forced to zero here so no read path can leak them
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_fault <= `CFS_ZERO32;
            o_curve <= `CFS_ZERO32;
            o_therm <= `CFS_ZERO32;
            o_fan <= `CFS_ZERO16;
        end
        else
        begin
            o_fault <= i_fault & `CFS_FAULT_MASK;
            o_curve <= i_curve & `CFS_CURVE_MASK;
            o_therm <= i_therm & `CFS_THERM_MASK;
            o_fan <= i_fan & `CFS_FAN_MASK;
        end
    end

endmodule

// ---- hdl/cfs_status_bank.v ----
// Operation
// - fault bits 0-2 lower-switch overcurrent A-C, bits 3-5 upper-switch.
// - fault bits 6-8 DC overcurrent per phase, bits 9-11 current imbalance.
// - fault bits 12-13 hardware link overvoltage, 14 link overvoltage, 15 imbalance.
// - fault bit 16 precharge timeout, 17 bias undervoltage, 18 interlock, 19 comms.
// - fault bit 20 logging, 21 config, 22 memory, 23 calibration; 24-31 zero.
// - curve word bits 1, 2, 3 flag invalid ride-through curves.
// - thermal bits 0-2 DC sink hot, 3 imbalance, 4-6 DC switch hot.
// - thermal bits 7-9 AC sink hot, bit 10 AC sink imbalance.
// - thermal bit 24 high ambient, bit 25 low ambient warning.
// - fan word bit 2 not spinning, bit 3 too slow; rest zero.
// - result code refreshed after every register read or write.
// - result 0 on success, 1 on illegal register number.
// - result 2 for write to read-only, 3 for read of write-only.
// - result 4 when written data is out of range.
// - result 5 on memory hardware fault, 6 on checksum mismatch.
// - result 7 on bad password, 8 when converter is running.
// - read-only 16-bit firmware part number register.
`timescale 1ns/1ps
`include "cfs_regs.vh"

module cfs_status_bank
(
    input wire I_REF_CLK,
    input wire I_RST,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [31:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [31:0] i_fault_flags,
    input wire [31:0] i_curve_flags,
    input wire [31:0] i_thermal_flags,
    input wire [15:0] i_fan_flags,
    input wire [15:0] i_part_number,
    output reg o_pready,
    output reg o_pslverr,
    output reg [31:0] o_prdata
);

    localparam ST_IDLE = 2'b01;
    localparam ST_DONE = 2'b10;

    // causes that no register of this bank can raise; the code table stays whole
    localparam NO_WRITE_ONLY = 1'b0;
    localparam NO_RANGE_LIMIT = 1'b0;
    localparam NO_MEMORY = 1'b0;
    localparam NO_PASSWORD = 1'b0;
    localparam NO_RUN_LOCK = 1'b0;

    wire [31:0] fault_w;
    wire [31:0] curve_w;
    wire [31:0] therm_w;
    wire [15:0] fan_w;
    wire take_w;

    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [15:0] result_reg;
    reg [15:0] result_next;
    reg [15:0] partnum_reg;
    reg [31:0] rdata_next;
    reg [31:0] fault_map;
    reg [31:0] curve_map;
    reg [31:0] therm_map;
    reg [15:0] fan_map;
    reg err_next;
    reg [15:0] idx;
    reg hit;

    cfs_flag_capture u_capture
    (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_fault(i_fault_flags),
        .i_curve(i_curve_flags),
        .i_therm(i_thermal_flags),
        .i_fan(i_fan_flags),
        .o_fault(fault_w),
        .o_curve(curve_w),
        .o_therm(therm_w),
        .o_fan(fan_w)
    );

    // picks low or high half of a 32-bit status word
    function [15:0] half_sel;
        input [31:0] word;
        input upper;
        begin
            half_sel = upper ? word[`CFS_HALF_HI] : word[`CFS_HALF_LO];
        end
    endfunction

    // register number carried by a byte address
    function [15:0] reg_number;
        input [31:0] addr;
        begin
            reg_number = addr[`CFS_ADDR_INDEX];
        end
    endfunction

    // only aligned words inside the low window name a register
    function addr_legal;
        input [31:0] addr;
        begin
            addr_legal = (addr[`CFS_ADDR_BYTE] == `CFS_ADDR_BYTE_ZERO)
                && (addr[`CFS_ADDR_TOP] == `CFS_ADDR_TOP_ZERO);
        end
    endfunction

    // priority of the access result codes: the first cause that applies wins
    function [15:0] result_code;
        input mapped;
        input write;
        input write_only;
        input out_of_range;
        input mem_hw_fail;
        input mem_crc_bad;
        input bad_password;
        input running;
        begin
            if (!mapped)
            begin
                result_code = `CFS_RES_BAD_REG;
            end
            else if (write)
            begin
                result_code = `CFS_RES_WR_RO;
            end
            else if (write_only)
            begin
                result_code = `CFS_RES_RD_WO;
            end
            else if (out_of_range)
            begin
                result_code = `CFS_RES_RANGE;
            end
            else if (mem_hw_fail)
            begin
                result_code = `CFS_RES_MEM_HW;
            end
            else if (mem_crc_bad)
            begin
                result_code = `CFS_RES_MEM_CRC;
            end
            else if (bad_password)
            begin
                result_code = `CFS_RES_PASSWORD;
            end
            else if (running)
            begin
                result_code = `CFS_RES_RUNNING;
            end
            else
            begin
                result_code = `CFS_RES_OK;
            end
        end
    endfunction

    assign take_w = (state_reg == ST_IDLE) && i_psel && i_penable;

    // flag words rebuilt field by field; a bit not named here reads zero
    always @*
    begin
        fault_map = `CFS_ZERO32;
        fault_map[`CFS_F_LOWER_OC] = fault_w[`CFS_F_LOWER_OC];
        fault_map[`CFS_F_UPPER_OC] = fault_w[`CFS_F_UPPER_OC];
        fault_map[`CFS_F_PHASE_OC] = fault_w[`CFS_F_PHASE_OC];
        fault_map[`CFS_F_CUR_IMBAL] = fault_w[`CFS_F_CUR_IMBAL];
        fault_map[`CFS_F_LINK_HW_OV] = fault_w[`CFS_F_LINK_HW_OV];
        fault_map[`CFS_F_LINK_OV] = fault_w[`CFS_F_LINK_OV];
        fault_map[`CFS_F_LINK_IMBAL] = fault_w[`CFS_F_LINK_IMBAL];
        fault_map[`CFS_F_PRECHARGE] = fault_w[`CFS_F_PRECHARGE];
        fault_map[`CFS_F_BIAS_UV] = fault_w[`CFS_F_BIAS_UV];
        fault_map[`CFS_F_INTERLOCK] = fault_w[`CFS_F_INTERLOCK];
        fault_map[`CFS_F_DCDC_COMM] = fault_w[`CFS_F_DCDC_COMM];
        fault_map[`CFS_F_LOG_ERR] = fault_w[`CFS_F_LOG_ERR];
        fault_map[`CFS_F_FACT_CFG] = fault_w[`CFS_F_FACT_CFG];
        fault_map[`CFS_F_CFG_MEM] = fault_w[`CFS_F_CFG_MEM];
        fault_map[`CFS_F_CAL_ERR] = fault_w[`CFS_F_CAL_ERR];
        // top byte is reserved and stays zero
    end

    always @*
    begin
        curve_map = `CFS_ZERO32;
        curve_map[`CFS_C_LOW_V] = curve_w[`CFS_C_LOW_V];
        curve_map[`CFS_C_HIGH_V] = curve_w[`CFS_C_HIGH_V];
        curve_map[`CFS_C_LOW_F] = curve_w[`CFS_C_LOW_F];
    end

    always @*
    begin
        therm_map = `CFS_ZERO32;
        therm_map[`CFS_T_DC_SINK_HOT] = therm_w[`CFS_T_DC_SINK_HOT];
        therm_map[`CFS_T_DC_SINK_IMBAL] = therm_w[`CFS_T_DC_SINK_IMBAL];
        therm_map[`CFS_T_DC_SWITCH_HOT] = therm_w[`CFS_T_DC_SWITCH_HOT];
        therm_map[`CFS_T_AC_SINK_HOT] = therm_w[`CFS_T_AC_SINK_HOT];
        therm_map[`CFS_T_AC_SINK_IMBAL] = therm_w[`CFS_T_AC_SINK_IMBAL];
        therm_map[`CFS_T_AMBIENT_HIGH] = therm_w[`CFS_T_AMBIENT_HIGH];
        therm_map[`CFS_T_AMBIENT_LOW] = therm_w[`CFS_T_AMBIENT_LOW];
    end

    always @*
    begin
        fan_map = `CFS_ZERO16;
        fan_map[`CFS_N_FAN_STOPPED] = fan_w[`CFS_N_FAN_STOPPED];
        fan_map[`CFS_N_FAN_SLOW] = fan_w[`CFS_N_FAN_SLOW];
    end

    always @*
    begin
        idx = reg_number(i_paddr);
        hit = 1'b1;
        rdata_next = `CFS_ZERO32;
        case (idx)
            `CFS_IDX_FAULT_LO:
            begin
                rdata_next[`CFS_HALF_LO] = half_sel(fault_map, 1'b0);
            end
            `CFS_IDX_FAULT_HI:
            begin
                rdata_next[`CFS_HALF_LO] = half_sel(fault_map, 1'b1);
            end
            `CFS_IDX_CURVE_LO:
            begin
                rdata_next[`CFS_HALF_LO] = half_sel(curve_map, 1'b0);
            end
            `CFS_IDX_CURVE_HI:
            begin
                rdata_next[`CFS_HALF_LO] = half_sel(curve_map, 1'b1);
            end
            `CFS_IDX_THERM_LO:
            begin
                rdata_next[`CFS_HALF_LO] = half_sel(therm_map, 1'b0);
            end
            `CFS_IDX_THERM_HI:
            begin
                rdata_next[`CFS_HALF_LO] = half_sel(therm_map, 1'b1);
            end
            `CFS_IDX_FAN:
            begin
                rdata_next[`CFS_HALF_LO] = fan_map;
            end
            `CFS_IDX_RESULT:
            begin
                rdata_next[`CFS_HALF_LO] = result_reg;
            end
            `CFS_IDX_PARTNUM:
            begin
                rdata_next[`CFS_HALF_LO] = partnum_reg;
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase
        // unaligned or out-of-window byte address is not a register number either
        if (!addr_legal(i_paddr))
        begin
            hit = 1'b0;
            rdata_next = `CFS_ZERO32;
        end
    end

    always @*
    begin
        state_next = state_reg;
        result_next = result_reg;
        err_next = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (take_w)
                begin
                    state_next = ST_DONE;
                    // every bank register is read-only; no write-only, ranged,
                    // password or memory-backed register exists here, so those
                    // causes are tied off and codes 3 to 8 never appear
                    result_next = result_code(hit, i_pwrite, NO_WRITE_ONLY, NO_RANGE_LIMIT,
                        NO_MEMORY, NO_MEMORY, NO_PASSWORD, NO_RUN_LOCK);
                    err_next = (result_next != `CFS_RES_OK);
                end
            end
            ST_DONE:
            begin
                state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            state_reg <= ST_IDLE;
            result_reg <= `CFS_RESULT_RESET;
        end
        else
        begin
            state_reg <= state_next;
            result_reg <= result_next;
        end
    end

    // one wait state: pready rises one cycle into the access phase
    always @(posedge I_REF_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= `CFS_ZERO32;
        end
        else
        begin
            if (take_w)
            begin
                o_pready <= 1'b1;
                o_pslverr <= err_next;
                // a read of the result register shows the code of the previous access
                o_prdata <= i_pwrite ? `CFS_ZERO32 : rdata_next;
            end
            else
            begin
                o_pready <= 1'b0;
                o_pslverr <= 1'b0;
                o_prdata <= `CFS_ZERO32;
            end
        end
    end

    // part number strap is caught on every rising clock edge, also while reset is held; reset never loads it
    always @(posedge I_REF_CLK)
    begin
        partnum_reg <= i_part_number;
    end

endmodule

// ---- sim/cfs_status_monitor.sv ----
`timescale 1ns/1ps
module cfs_status_monitor
(
    input wire I_REF_CLK,
    input wire I_RST,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [31:0] i_paddr,
    input wire [15:0] i_part_number,
    input wire o_pready,
    input wire o_pslverr,
    input wire [31:0] o_prdata
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    wire mapped = i_paddr >= 32'h0002_8C80 && i_paddr <= 32'h0002_8CA0 && i_paddr[1:0] == 2'h0;
    wire rd_ok = mapped && !i_pwrite;
    sequence s_take;
        i_psel && i_penable && !o_pready;
    endsequence
    sequence s_pulse;
        o_pready ##1 !o_pready;
    endsequence
    a_single_answer: assert property (s_take |=> s_pulse) else $error("no ready pulse");
    a_ready_cause: assert property (o_pready |-> $past(i_psel && i_penable)) else $error("stray");
    a_error_flag: assert property (o_pready |-> o_pslverr == !$past(rd_ok)) else $error("err");
    a_upper_zero: assert property (o_pready |-> o_prdata[31:16] == 16'h0000) else $error("hi");
    a_idle_quiet: assert property (!o_pready |-> !o_pslverr && o_prdata == 32'h0) else $error("idle");
    a_fan_reserved: assert property (o_pready && $past(rd_ok && i_paddr[7:0] == 8'h98)
        |-> (o_prdata & 32'hFFFF_FFF3) == 32'h0) else $error("fan");
    a_fault_reserved: assert property (o_pready && $past(rd_ok && i_paddr[7:0] == 8'h84)
        |-> o_prdata[15:8] == 8'h00) else $error("fault");
    a_part_number: assert property (o_pready && $past(rd_ok && i_paddr[7:0] == 8'hA0)
        |-> o_prdata[15:0] == $past(i_part_number, 2)) else $error("part");
endmodule

// ---- sim/test_cfs_status_bank.sv ----
`timescale 1ns/1ps
module test_cfs_status_bank;
    logic I_REF_CLK = 1'h0;
    logic I_RST = 1'h1;
    logic i_psel = 1'h0, i_penable = 1'h0, i_pwrite = 1'h0, err;
    logic [31:0] i_paddr = '0, i_pwdata = 32'hFFFF_FFFF, rd, m;
    logic [31:0] i_fault_flags = '0, i_curve_flags = '0, i_thermal_flags = '0;
    logic [15:0] i_fan_flags = '0, i_part_number = 16'hC3A5;
    wire o_pready, o_pslverr;
    wire [31:0] o_prdata;
    int miscompares = 0, checked = 0;
    always #2 I_REF_CLK = ~I_REF_CLK;
    cfs_status_bank dut (.I_REF_CLK, .I_RST, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .i_fault_flags, .i_curve_flags, .i_thermal_flags, .i_fan_flags, .i_part_number,
        .o_pready, .o_pslverr, .o_prdata);
    task tally_and_finish;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // request held until ready is seen at an edge, then released
    task apb(input logic w, input logic [15:0] idx);
        int n;
        i_psel <= 1'h1;
        i_pwrite <= w;
        i_paddr <= {14'h0, idx, 2'h0};
        @(posedge I_REF_CLK);
        i_penable <= 1'h1;
        n = 0;
        // outputs are looked at where settled, just before the edge that samples them
        do
        begin
            @(negedge I_REF_CLK);
            n++;
        end
        while (o_pready !== 1'h1 && n < 9);
        rd = o_prdata;
        err = o_pslverr;
        chk({31'h0, o_pready}, 32'h1);
        @(posedge I_REF_CLK);
        i_psel <= 1'h0;
        i_penable <= 1'h0;
        @(posedge I_REF_CLK);
    endtask
    task step(input logic w, input logic [15:0] idx, input logic [31:0] ee, input logic [31:0] c);
        apb(w, idx);
        chk({31'h0, err}, ee);
        apb(1'h0, 16'hA327);
        chk(rd, c);
    endtask
    task t_result;
        apb(1'h0, 16'hA327);
        chk(rd, 32'h0);
        step(1'h1, 16'hA320, 32'h1, 32'h2);
        apb(1'h0, 16'hA320);
        chk(rd, 32'h0);
        step(1'h0, 16'hA31F, 32'h1, 32'h1);
        step(1'h0, 16'hA329, 32'h1, 32'h1);
        step(1'h1, 16'hA327, 32'h1, 32'h2);
        step(1'h0, 16'hA328, 32'h0, 32'h0);
        apb(1'h0, 16'hA328);
        chk(rd, 32'h0000_C3A5);
        $display("test result done");
    endtask
    task t_status;
        logic [31:0] p;
        for (int k = 0; k < 2; k++)
        begin
            p = k ? 32'h5A5A_A5A5 : 32'hFFFF_FFFF;
            i_fault_flags <= p;
            i_curve_flags <= p;
            i_thermal_flags <= p;
            i_fan_flags <= p[15:0];
            repeat (2) @(posedge I_REF_CLK);
            for (int j = 0; j < 7; j++)
            begin
                m = p & (j < 2 ? 32'h00FF_FFFF : j < 4 ? 32'h0000_000E :
                    j < 6 ? 32'h0300_07FF : 32'h0000_000C);
                apb(1'h0, 16'hA320 + j[15:0]);
                chk(rd, j % 2 ? m >> 16 : m & 32'hFFFF);
                chk({31'h0, err}, 32'h0);
            end
        end
        $display("test status done");
    endtask
    task t_reset;
        apb(1'h1, 16'hA324);
        I_RST <= 1'h1;
        repeat (3) @(posedge I_REF_CLK);
        I_RST <= 1'h0;
        @(posedge I_REF_CLK);
        apb(1'h0, 16'hA327);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask
    initial
    begin
        repeat (3) @(posedge I_REF_CLK);
        I_RST <= 1'h0;
        @(posedge I_REF_CLK);
        t_result;
        t_status;
        t_reset;
        tally_and_finish;
    end
    initial
    begin
        repeat (5000) @(posedge I_REF_CLK);
        miscompares++;
        tally_and_finish;
    end
endmodule
bind cfs_status_bank cfs_status_monitor u_mon (.I_REF_CLK, .I_RST, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_part_number, .o_pready, .o_pslverr, .o_prdata);
